/* src/charger_status_pkg.sv */
// constants shared by the charger status register bank
package charger_status_pkg;

	// ----------------------------------------------------------------
	// register offsets and widths
	// ----------------------------------------------------------------
	localparam int        ADDR_W            = 8;
	localparam int        DATA_W            = 8;
	localparam logic [7:0] STATUS_ONE_OFFSET = 8'h0B;
	localparam logic [7:0] STATUS_TWO_OFFSET = 8'h0C;
	localparam logic [7:0] THERM_OFFSET      = 8'h0D;
	localparam logic [7:0] FLAG_ONE_OFFSET   = 8'h0F;
	localparam logic [7:0] BYTE_ZERO         = 8'h00;

	// ----------------------------------------------------------------
	// field positions inside the registers
	// ----------------------------------------------------------------
	localparam int ADC_DONE_BIT   = 7;
	localparam int IIN_BIT        = 6;
	localparam int VIN_BIT        = 5;
	localparam int TREG_BIT       = 4;
	localparam int WD_BIT         = 3;
	localparam int PHASE_LSB      = 0;
	localparam int PG_BIT         = 7;
	localparam int SRC_LSB        = 4;
	localparam int ICO_LSB        = 1;
	localparam int VSYS_BIT       = 0;
	localparam int TS_LSB         = 0;
	localparam int PHASE_FLAG_BIT = 0;
	localparam int REG_LOOPS      = 4;

	// ----------------------------------------------------------------
	// layout of the synchronised condition vector
	// ----------------------------------------------------------------
	localparam int C_ADC_DONE = 0;
	localparam int C_ADC_CONT = 1;
	localparam int C_IIN      = 2;
	localparam int C_PHASE    = 6;
	localparam int C_PG       = 9;
	localparam int C_SRC      = 10;
	localparam int C_ICO      = 13;
	localparam int C_VSYS     = 15;
	localparam int C_TS       = 16;
	localparam int C_TS_VALID = 19;
	localparam int COND_W     = 20;
	localparam logic [COND_W-1:0] COND_RESET = '0;

endpackage

/* src/condition_if.sv */
// carrier for the filtered condition vector between the bank's modules
`timescale 1ns/1ps
interface condition_if;
	import charger_status_pkg::*;
	logic [COND_W-1:0] cond;
	modport source (output cond);
	modport sink   (input  cond);
endinterface

/* src/condition_sync.sv */
// two-flop synchroniser and settle filter for the sensing inputs
`timescale 1ns/1ps
module condition_sync
	import charger_status_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              reset_n_in,
	// raw conditions from the analog side
	input  wire logic [COND_W-1:0] raw_in,
	// filtered conditions
	condition_if.source            out
);

	logic [COND_W-1:0] meta;
	logic [COND_W-1:0] sync;
	logic [COND_W-1:0] prev;
	wire               settled = (sync == prev);

	// ----------------------------------------------------------------
	// per-bit synchroniser
	// ----------------------------------------------------------------
	for (genvar i = 0; i < COND_W; i++) begin : g_sync
		always_ff @(posedge core_clk_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				meta[i] <= 1'b0;
				sync[i] <= 1'b0;
			end else begin
				meta[i] <= raw_in[i];
				sync[i] <= meta[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// settle filter
	// ----------------------------------------------------------------
	// multi-bit codes may skew by a cycle across the synchroniser;
	// taking only a vector that held for two samples hides the blend
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prev     <= COND_RESET;
			out.cond <= COND_RESET;
		end else begin
			prev <= sync;
			if (settled) begin
				out.cond <= sync;
			end
		end
	end

endmodule

/* src/change_flag_latch.sv */
// sticky flags set by status rising edges and charge phase changes
`timescale 1ns/1ps
module change_flag_latch
	import charger_status_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              reset_n_in,
	// filtered conditions
	condition_if.sink              src,
	// clear requests
	input  wire logic              clear_in,
	// latched flags
	output logic [DATA_W-1:0]      flags_out
);

	logic [COND_W-1:0] last;
	logic [DATA_W-1:0] next_flags;
	logic [DATA_W-1:0] events;
	wire               done_now  = src.cond[C_ADC_DONE] & ~src.cond[C_ADC_CONT];
	wire               done_last = last[C_ADC_DONE] & ~last[C_ADC_CONT];

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	always_comb begin
		events = BYTE_ZERO;
		events[ADC_DONE_BIT] = done_now & ~done_last;
		for (int i = 0; i < REG_LOOPS; i++) begin
			events[IIN_BIT-i] = src.cond[C_IIN+i] & ~last[C_IIN+i];
		end
		events[PHASE_FLAG_BIT] =
			(src.cond[C_PHASE+:3] != last[C_PHASE+:3]);
	end

	// an event in the clearing cycle survives the clear
	assign next_flags = (clear_in ? BYTE_ZERO : flags_out) | events;

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last      <= COND_RESET;
			flags_out <= BYTE_ZERO;
		end else begin
			last      <= src.cond;
			flags_out <= next_flags;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_rise_sets_flag: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		$rose(src.cond[C_IIN]) |=> flags_out[IIN_BIT])
		else $error("input current rise did not set its flag");

	a_phase_change_flag: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!$stable(src.cond[C_PHASE+:3]) |=> flags_out[PHASE_FLAG_BIT])
		else $error("charge phase change did not set its flag");

endmodule

/* src/charger_status_registers.sv */
// read-only status register bank of the battery charger
`timescale 1ns/1ps
module charger_status_registers
	import charger_status_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              reset_n_in,
	// converter conditions
	input  wire logic              adc_one_shot_done_in,
	input  wire logic              adc_continuous_in,
	// regulation loop conditions
	input  wire logic              input_current_limiting_in,
	input  wire logic              input_voltage_limiting_in,
	input  wire logic              thermal_regulating_in,
	input  wire logic              watchdog_expired_in,
	input  wire logic [2:0]        charge_phase_in,
	// input source conditions
	input  wire logic              power_good_state_in,
	input  wire logic [2:0]        input_source_type_in,
	input  wire logic [1:0]        current_optimizer_state_in,
	input  wire logic              min_system_regulating_in,
	// thermistor sensing
	input  wire logic [2:0]        thermistor_zone_in,
	input  wire logic              thermistor_valid_in,
	// register access port
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic              reg_rd_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_reset_in,
	output logic [DATA_W-1:0]      reg_rdata_out,
	output logic                   reg_ack_out,
	// latched flags
	output logic [DATA_W-1:0]      flag_one_out
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic hits(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		hits = (a == off);
	endfunction

	// ----------------------------------------------------------------
	// condition capture
	// ----------------------------------------------------------------
	condition_if       link ();
	logic [COND_W-1:0] raw;
	logic              ts_seen;

	assign raw = {
		thermistor_valid_in,
		thermistor_zone_in,
		min_system_regulating_in,
		current_optimizer_state_in,
		input_source_type_in,
		power_good_state_in,
		charge_phase_in,
		watchdog_expired_in,
		thermal_regulating_in,
		input_voltage_limiting_in,
		input_current_limiting_in,
		adc_continuous_in,
		adc_one_shot_done_in
	};

	condition_sync u_sync (
		.core_clk_in (core_clk_in),
		.reset_n_in  (reset_n_in),
		.raw_in      (raw),
		.out         (link.source)
	);

	// ----------------------------------------------------------------
	// status register images
	// ----------------------------------------------------------------
	// the images are wiring off the filtered conditions, the zone gated by ts_seen: no write
	// path and no soft reset reaches them
	wire [COND_W-1:0] c = link.cond;
	wire              adc_done_bit = c[C_ADC_DONE] & ~c[C_ADC_CONT];
	logic [DATA_W-1:0] status_one;
	logic [DATA_W-1:0] status_two;
	logic [DATA_W-1:0] therm_status;

	always_comb begin
		status_one = BYTE_ZERO;
		status_one[ADC_DONE_BIT] = adc_done_bit;
		status_one[IIN_BIT]      = c[C_IIN];
		status_one[VIN_BIT]      = c[C_IIN+1];
		status_one[TREG_BIT]     = c[C_IIN+2];
		status_one[WD_BIT]       = c[C_IIN+3];
		status_one[PHASE_LSB+:3] = c[C_PHASE+:3];
	end

	always_comb begin
		status_two = BYTE_ZERO;
		status_two[PG_BIT]       = c[C_PG];
		status_two[SRC_LSB+:3]   = c[C_SRC+:3];
		status_two[ICO_LSB+:2]   = c[C_ICO+:2];
		status_two[VSYS_BIT]     = c[C_VSYS];
	end

	always_comb begin
		therm_status = BYTE_ZERO;
		if (ts_seen) begin
			therm_status[TS_LSB+:3] = c[C_TS+:3];
		end
	end

	// zone reads zero until the sensor has produced its first result
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ts_seen <= 1'b0;
		end else if (c[C_TS_VALID]) begin
			ts_seen <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// flag latch
	// ----------------------------------------------------------------
	wire rd_status_one = hits(reg_addr_in, STATUS_ONE_OFFSET);
	wire rd_status_two = hits(reg_addr_in, STATUS_TWO_OFFSET);
	wire rd_therm      = hits(reg_addr_in, THERM_OFFSET);
	wire rd_flag_one   = hits(reg_addr_in, FLAG_ONE_OFFSET);
	// reading the flags clears them; a soft register reset does too
	wire flag_clear    = (reg_rd_in & rd_flag_one) | reg_reset_in;
	logic [DATA_W-1:0] flags;

	change_flag_latch u_flags (
		.core_clk_in (core_clk_in),
		.reset_n_in  (reset_n_in),
		.src         (link.sink),
		.clear_in    (flag_clear),
		.flags_out   (flags)
	);

	assign flag_one_out = flags;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// writes are acknowledged but land nowhere; unmapped reads give zero
	logic [DATA_W-1:0] read_sel;

	assign read_sel =
		rd_status_one ? status_one :
		rd_status_two ? status_two :
		rd_therm      ? therm_status :
		rd_flag_one   ? flags :
		BYTE_ZERO;

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= BYTE_ZERO;
			reg_ack_out   <= 1'b0;
		end else begin
			reg_ack_out <= reg_rd_in | reg_wr_in;
			if (reg_rd_in) begin
				reg_rdata_out <= read_sel;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence read_of(logic [ADDR_W-1:0] off);
		reg_rd_in && reg_addr_in == off;
	endsequence

	// a read is answered on the following edge
	sequence read_answer(logic [ADDR_W-1:0] off);
		read_of(off) ##1 reg_ack_out;
	endsequence

	a_adc_cont_zero: assert property (
		(c[C_ADC_CONT] and read_of(STATUS_ONE_OFFSET))
		|=> !reg_rdata_out[ADC_DONE_BIT])
		else $error("conversion-done read 1 in continuous mode");

	a_adc_done_read: assert property (
		(!c[C_ADC_CONT] and read_of(STATUS_ONE_OFFSET))
		|=> reg_rdata_out[ADC_DONE_BIT] == $past(c[C_ADC_DONE]))
		else $error("conversion-done bit read wrong in one-shot mode");

	a_status_one_read: assert property (
		read_answer(STATUS_ONE_OFFSET)
		|-> reg_rdata_out[IIN_BIT] == $past(c[C_IIN])
			&& reg_rdata_out[VIN_BIT] == $past(c[C_IIN+1]))
		else $error("input loop bits read wrong");

	a_treg_wd_read: assert property (
		read_of(STATUS_ONE_OFFSET)
		|=> reg_rdata_out[WD_BIT+:2] == {$past(c[C_IIN+2]),
			$past(c[C_IIN+3])})
		else $error("thermal or watchdog bit read wrong");

	a_phase_field: assert property (
		read_of(STATUS_ONE_OFFSET)
		|=> reg_rdata_out[PHASE_LSB+:3] == $past(c[C_PHASE+:3]))
		else $error("charge phase field read wrong");

	a_status_two_read: assert property (
		read_of(STATUS_TWO_OFFSET)
		|=> reg_rdata_out == {$past(c[C_PG]), $past(c[C_SRC+:3]),
			1'b0, $past(c[C_ICO+:2]), $past(c[C_VSYS])})
		else $error("status two read wrong");

	a_therm_reserved: assert property (
		read_of(THERM_OFFSET) |=> reg_rdata_out[DATA_W-1:3] == 5'h00)
		else $error("thermistor reserved bits not zero");

	a_therm_zone: assert property (
		(ts_seen and read_of(THERM_OFFSET))
		|=> reg_rdata_out[TS_LSB+:3] == $past(c[C_TS+:3]))
		else $error("thermistor zone read wrong");

	a_therm_before: assert property (
		(!ts_seen and read_of(THERM_OFFSET))
		|=> reg_rdata_out == BYTE_ZERO)
		else $error("thermistor register not zero before first result");

	a_therm_sticky: assert property (
		ts_seen |=> ts_seen)
		else $error("thermistor result marker dropped");

	// ----------------------------------------------------------------
	// checks on the access port
	// ----------------------------------------------------------------
	// a change of the conditions in the answer cycle moves the images
	// legitimately, so only a quiet cycle is held against a write
	a_write_ignored: assert property (
		reg_wr_in && !reg_rd_in
		|=> reg_ack_out && $stable(reg_rdata_out) && (!$stable(c)
			|| ($stable(status_one) && $stable(status_two))))
		else $error("write disturbed a status register");

	a_ack_pulse: assert property (
		reg_rd_in || reg_wr_in |=> reg_ack_out)
		else $error("access not acknowledged");

	a_ack_idle: assert property (
		!reg_rd_in && !reg_wr_in |=> !reg_ack_out)
		else $error("acknowledge without an access");

	a_rdata_holds: assert property (
		!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without a read");

	a_unmapped_zero: assert property (
		reg_rd_in && !rd_status_one && !rd_status_two && !rd_therm
		&& !rd_flag_one |=> reg_rdata_out == BYTE_ZERO)
		else $error("unmapped read returned nonzero data");

	// ----------------------------------------------------------------
	// checks on the latched flags
	// ----------------------------------------------------------------
	a_flag_read_clear: assert property (
		(read_of(FLAG_ONE_OFFSET) and !reg_reset_in)
		|=> reg_rdata_out == $past(flags))
		else $error("flag register read wrong");

	// with the conditions quiet no event can outlive the clear
	a_read_clears: assert property (
		(read_of(FLAG_ONE_OFFSET) and $stable(c))
		|=> flags == BYTE_ZERO)
		else $error("flag read did not clear the flags");

	a_soft_reset_clears: assert property (
		reg_reset_in && $stable(c) |=> flags == BYTE_ZERO)
		else $error("soft register reset did not clear the flags");

	a_flag_reserved: assert property (
		flags[WD_BIT-1:PHASE_FLAG_BIT+1] == 2'h0)
		else $error("reserved flag bits not zero");

	a_wd_rise_flag: assert property (
		$rose(c[C_IIN+3]) |=> flags[WD_BIT])
		else $error("watchdog rise did not set its flag");

	a_adc_rise_flag: assert property (
		$rose(adc_done_bit) |=> flags[ADC_DONE_BIT])
		else $error("conversion completion did not set its flag");

endmodule

/* verification/status_host_model.sv */
// host-side model that issues accesses to the status register bank
`timescale 1ns/1ps
module status_host_model
	import charger_status_pkg::*;
(
	// clock
	input  wire logic              core_clk_in,
	// register access
	output logic [ADDR_W-1:0]      addr_out,
	output logic                   rd_out,
	output logic                   wr_out,
	output logic                   soft_reset_out,
	input  wire logic              ack_in
);
	initial begin
		addr_out = 8'h00;
		rd_out = 1'b0;
		wr_out = 1'b0;
		soft_reset_out = 1'b0;
	end

	// ----------------------------------------------------------------
	// one access: single-cycle strobe, then a bounded wait for the ack
	// ----------------------------------------------------------------
	task automatic access(input logic [ADDR_W-1:0] a, input logic write);
		int n;
		@(posedge core_clk_in);
		addr_out <= a;
		rd_out <= ~write;
		wr_out <= write;
		@(posedge core_clk_in);
		rd_out <= 1'b0;
		wr_out <= 1'b0;
		// released address shows a different value, not the stale one
		addr_out <= ~a;
		n = 0;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (ack_in !== 1'b1 && n < 4);
	endtask

	task automatic pulse_reset();
		@(posedge core_clk_in);
		soft_reset_out <= 1'b1;
		@(posedge core_clk_in);
		soft_reset_out <= 1'b0;
	endtask
endmodule

/* verification/charger_status_registers_tb.sv */
// self-checking bench for the charger status register bank
`timescale 1ns/1ps
module charger_status_registers_tb;
	import charger_status_pkg::*;
	logic        core_clk_in = 1'b0;
	logic        reset_n_in  = 1'b0;
	logic        done = 0, cont = 0, iin = 0, vin = 0, treg = 0;
	logic        wd = 0, pg = 0, vsys = 0, tsv = 0;
	logic [2:0]  phase = 0, src = 0, zone = 0;
	logic [1:0]  current_optimizer = 0;
	logic [7:0]  addr, rdata, flags;
	logic        rd, wr, rrst, ack;
	logic [8:0]  notes[$];
	logic [8:0]  n;
	logic [31:0] lfsr = 32'h0398;
	int          errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;

	always #25 core_clk_in = ~core_clk_in;

	charger_status_registers i_dut (.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in), .adc_one_shot_done_in(done),
		.adc_continuous_in(cont), .input_current_limiting_in(iin),
		.input_voltage_limiting_in(vin), .thermal_regulating_in(treg),
		.watchdog_expired_in(wd), .charge_phase_in(phase),
		.power_good_state_in(pg), .input_source_type_in(src),
		.current_optimizer_state_in(current_optimizer), .min_system_regulating_in(vsys),
		.thermistor_zone_in(zone), .thermistor_valid_in(tsv),
		.reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr),
		.reg_reset_in(rrst), .reg_rdata_out(rdata), .reg_ack_out(ack),
		.flag_one_out(flags));

	status_host_model i_host (.core_clk_in(core_clk_in), .addr_out(addr),
		.rd_out(rd), .wr_out(wr), .soft_reset_out(rrst), .ack_in(ack));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] next_lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// a note with bit 8 low marks an ack whose data is not compared
	task automatic rd_exp(input logic [7:0] a, input logic [8:0] e);
		notes.push_back(e);
		i_host.access(a, 1'b0);
	endtask

	task automatic settle();
		repeat (6) @(posedge core_clk_in);
	endtask

	task automatic read_bank();
		logic [8:0] one, two, th;
		one = {1'b1, done & ~cont, iin, vin, treg, wd, phase};
		two = {1'b1, pg, src, 1'b0, current_optimizer, vsys};
		th  = {1'b1, 5'h00, zone};
		rd_exp(STATUS_ONE_OFFSET, one);
		rd_exp(STATUS_TWO_OFFSET, two);
		rd_exp(THERM_OFFSET, th);
	endtask

	task automatic complete_run();
		cmp_count++;
		if (notes.size() != 0)
			errors++;
		if (errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// monitor: every ack retires the oldest note
	// ----------------------------------------------------------------
	always @(posedge core_clk_in) begin
		if (ack === 1'b1) begin
			if (notes.size() == 0) begin
				check("unexpected ack", 8'h00, 8'h01);
			end else begin
				n = notes.pop_front();
				if (n[8])
					check("reg_rdata_out", n[7:0], rdata);
			end
		end
	end

	// hang guard: the whole sequence needs well under 1500 cycles
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles > 3000) begin
			errors++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		zone <= 3'h5;
		settle();
		rd_exp(THERM_OFFSET, 9'h100);
		for (int i = 0; i < 8; i++) begin
			lfsr = next_lfsr(lfsr);
			{iin, vin, treg, wd, pg, vsys} <= lfsr[5:0];
			done <= ~i[1];
			cont <= i[0];
			phase <= i[2:0];
			src <= 3'(7 - i);
			zone <= i[2:0];
			current_optimizer <= 2'(i);
			tsv <= 1'b1;
			settle();
			read_bank();
		end
		// writes and soft reset leave the status images alone
		notes.push_back(9'h000);
		i_host.access(STATUS_ONE_OFFSET, 1'b1);
		notes.push_back(9'h000);
		i_host.access(STATUS_TWO_OFFSET, 1'b1);
		i_host.pulse_reset();
		read_bank();
		rd_exp(8'h0E, 9'h100);
		rd_exp(8'hFF, 9'h100);
		// latched flags: clear, then rises and a phase change
		{done, iin, vin, treg, wd} <= 5'h00;
		cont <= 1'b0;
		settle();
		rd_exp(FLAG_ONE_OFFSET, 9'h000);
		rd_exp(FLAG_ONE_OFFSET, 9'h100);
		{done, iin, vin, treg, wd} <= 5'h1F;
		phase <= phase + 3'h1;
		settle();
		check("flag_one_out", 8'hF9, flags);
		rd_exp(FLAG_ONE_OFFSET, 9'h1F9);
		rd_exp(FLAG_ONE_OFFSET, 9'h100);
		{done, iin, vin, treg, wd} <= 5'h00;
		settle();
		rd_exp(FLAG_ONE_OFFSET, 9'h100);
		wd <= 1'b1;
		settle();
		check("flag_one_out", 8'h08, flags);
		i_host.pulse_reset();
		@(posedge core_clk_in);
		check("flag_one_out", 8'h00, flags);
		// reset in mid-run clears the outputs, then tracking resumes
		reset_n_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		check("reg_rdata_out", 8'h00, rdata);
		check("flag_one_out", 8'h00, flags);
		reset_n_in <= 1'b1;
		settle();
		read_bank();
		repeat (4) @(posedge core_clk_in);
		complete_run();
	end
endmodule
